/* pkg/iued_pkg.sv */
// constants for the isa usb eval glue decoder
package iued_pkg;
  // window offsets on the low three address bits
  localparam logic [2:0] OFF_CTRL_DATA = 3'h0;
  localparam logic [2:0] OFF_CTRL_CMD  = 3'h1;
  localparam logic [2:0] OFF_IN_PORT   = 3'h2;
  localparam logic [2:0] OFF_OUT_PORT  = 3'h3;
  localparam logic [2:0] OFF_EXP_FIRST = 3'h4;
  localparam logic [2:0] OFF_EXP_LAST  = 3'h7;
  // input port field positions
  localparam int IN_KEY_LO   = 0;
  localparam int IN_KEY_HI   = 3;
  localparam int IN_LINK     = 4;
  localparam int IN_VBUS     = 5;
  localparam int IN_SUSPEND  = 6;
  localparam int IN_INT_N    = 7;
  // output port field positions
  localparam int OUT_LAMP_LO = 0;
  localparam int OUT_LAMP_HI = 3;
  localparam int OUT_SUSP    = 6;
  localparam int OUT_INT_EN  = 7;
  // reset values
  localparam logic [7:0] OUT_PORT_RST = 8'h00;
  localparam logic [2:0] SYNC_RST     = 3'h0;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
endpackage

/* src/iued_sync.sv */
// three-stage pin synchroniser with second/third agreement filter
module iued_sync #(
  parameter int  WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] st1_q, st2_q, st3_q, out_q;
  logic [WIDTH-1:0] out_d;

  genvar i;
  // per bit: accept a change only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        out_d[i] = (st2_q[i] == st3_q[i]) ? st3_q[i] : out_q[i];
      end
    end
  endgenerate

  // first stage feeds only the second, never the filter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
      out_q <= '0;
    end else begin
      st1_q <= pinIn;
      st2_q <= st1_q;
      st3_q <= st2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule

/* src/iued_glue_decoder.sv */
// isa io window decoder, test ports and interrupt gating for a usb controller
// Functional notes
// - offset 0 reaches controller data, rw
// - offset 1 writes controller command only
// - offset 2 is read-only input port
// - offset 3 is write-only output port
// - offsets 4 to 7 left unused
// - input bits 0-3 buttons, 0 pressed
// - input bit 5 shows bus power
// - bits 4,6,7 link, suspend, int_n
// - output bits 0-3 light test lamps
// - output bit 6 forces suspend low
// - irq high when enable and int asserted
// - irq falls when int deasserts, four to five clocks later through the synchroniser and register
// - chip select on window, a2a1 zero, strobe
// - input read enable at 010 read
// - output write strobe at 011 write
// - direction on dack with window select, read, or reset
// - wait driven only with chip select
// - dma request follows the controller, synchronised and registered
module iued_glue_decoder (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // isa side
  input  wire logic       busReset,
  input  wire logic       boardSel_n,
  input  wire logic [2:0] busAddr,
  input  wire logic       ioRead_n,
  input  wire logic       ioWrite_n,
  input  wire logic       dmaAck_n,
  input  wire logic       termCount,
  input  wire logic [7:0] busDataIn,
  output logic      [7:0] busDataOut,
  output logic            busDataOe_n,
  output logic            xcvrDirRead,
  output logic            busIrq,
  output logic            busDrq,
  output logic            busWaitOut,
  output logic            busWaitOe_n,
  // controller side
  input  wire logic [7:0] ctrlDataIn,
  output logic      [7:0] ctrlDataOut,
  output logic            ctrlDataOe_n,
  output logic            ctrl_chip_select,
  output logic            ctrlAddr0,
  output logic            ctrlRead_n,
  output logic            ctrlWrite_n,
  output logic            ctrlReset_n,
  output logic            ctrlSuspendLow,
  input  wire logic       ctrlInt_n,
  input  wire logic       ctrlLink,
  input  wire logic       ctrlSuspend,
  input  wire logic       ctrlDmaReq,
  output logic            ctrlDmaAck_n,
  output logic            ctrlEot,
  // board test pins
  input  wire logic [3:0] test_button_one,
  input  wire logic       usbVbus,
  output logic      [3:0] test_lamp_one,
  output logic            inPortRdEn,
  output logic            outPortWrStb
);
  // all isa and board pins come from outside the clock domain
  localparam int NSYNC = 26;
  logic [NSYNC-1:0] pinRaw, pinSync;

  // idle-high pins enter inverted: the zeroed synchroniser then reads idle, so no
  // false strobe or controller write follows reset
  assign pinRaw = {busReset, !boardSel_n, busAddr, !ioRead_n, !ioWrite_n, !dmaAck_n,
                   termCount, busDataIn, !ctrlInt_n, ctrlLink, ctrlSuspend,
                   ctrlDmaReq, ~test_button_one, usbVbus};

  iued_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (pinRaw),
    .syncOut  (pinSync)
  );

  // controller read data has its own eight-bit synchroniser
  logic [7:0] ctrlDataSync;
  iued_sync #(
    .WIDTH (8)
  ) u_sync_cd (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (ctrlDataIn),
    .syncOut  (ctrlDataSync)
  );

  logic       sReset, sSel_n, sRd_n, sWr_n, sDack_n, sTc;
  logic       sInt_n, sLink, sSusp, sDrq, sVbus;
  logic [2:0] sAddr;
  logic [7:0] sBusData;
  logic [3:0] sKeys;

  assign sReset   = pinSync[25];
  assign sSel_n   = !pinSync[24];
  assign sAddr    = pinSync[23:21];
  assign sRd_n    = !pinSync[20];
  assign sWr_n    = !pinSync[19];
  assign sDack_n  = !pinSync[18];
  assign sTc      = pinSync[17];
  assign sBusData = pinSync[16:9];
  assign sInt_n   = !pinSync[8];
  assign sLink    = pinSync[7];
  assign sSusp    = pinSync[6];
  assign sDrq     = pinSync[5];
  assign sKeys    = ~pinSync[4:1];
  assign sVbus    = pinSync[0];

  // decoded terms from the synchronised bus
  logic winSel, rdAct, wrAct, ctrlHit, inHit, outHit, expHit;

  // window select is the host's active-low decode
  assign winSel = !sSel_n;
  assign rdAct  = !sRd_n;
  assign wrAct  = !sWr_n;
  assign ctrlHit = winSel && (sAddr[2:1] == iued_pkg::OFF_CTRL_DATA[2:1]) && (rdAct || wrAct);
  assign inHit   = winSel && (sAddr == iued_pkg::OFF_IN_PORT) && rdAct;
  assign outHit  = winSel && (sAddr == iued_pkg::OFF_OUT_PORT) && wrAct;
  // expansion range selects no device; it only masks the dma read drive
  assign expHit  = winSel && (sAddr >= iued_pkg::OFF_EXP_FIRST) &&
                   (sAddr <= iued_pkg::OFF_EXP_LAST);

  // output port and registered pins
  logic [7:0] outPort_q, outPort_d;
  logic       wrPrev_q, wrPrev_d;
  logic [7:0] busDataOut_q, busDataOut_d;
  logic       busDataOe_n_q, busDataOe_n_d;
  logic [7:0] ctrlDataOut_q, ctrlDataOut_d;
  logic       ctrlDataOe_n_q, ctrlDataOe_n_d;
  logic       dir_q, dir_d;
  logic       irq_q, irq_d;
  logic       drq_q, drq_d;
  logic       wait_q, wait_d;
  logic       waitOe_n_q, waitOe_n_d;
  logic       cs_q, cs_d;
  logic       a0_q, a0_d;
  logic       cRd_n_q, cRd_n_d;
  logic       cWr_n_q, cWr_n_d;
  logic       cRst_n_q, cRst_n_d;
  logic       dack_n_q, dack_n_d;
  logic       eot_q, eot_d;
  logic       inEn_q, inEn_d;
  logic       outStb_q, outStb_d;
  logic [7:0] inPortVal;

  // input port image; keys read 0 while pressed
  always_comb begin
    inPortVal = 8'h00;
    inPortVal[iued_pkg::IN_KEY_HI:iued_pkg::IN_KEY_LO] = sKeys;
    inPortVal[iued_pkg::IN_LINK]    = sLink;
    inPortVal[iued_pkg::IN_VBUS]    = sVbus;
    inPortVal[iued_pkg::IN_SUSPEND] = sSusp;
    inPortVal[iued_pkg::IN_INT_N]   = sInt_n;
  end

  // next values for every registered output
  always_comb begin
    outPort_d = outPort_q;
    wrPrev_d  = outHit;
    // latch output port on the write strobe's rising edge
    if (outHit && !wrPrev_q) begin
      outPort_d = sBusData;
    end
    // bus reset clears the port, like power-up
    if (sReset) begin
      outPort_d = iued_pkg::OUT_PORT_RST;
    end
    cs_d     = ctrlHit;
    // offset 0 data, offset 1 command via address bit 0
    a0_d     = sAddr[0];
    // read strobe follows bus, reset inverted
    cRd_n_d  = sRd_n;
    // command offset takes writes; reads of it are harmless
    cWr_n_d  = !(wrAct && (ctrlHit || (!sDack_n && winSel)));
    cRst_n_d = !sReset;
    inEn_d   = inHit;
    outStb_d = outHit;
    dir_d    = (winSel && !sDack_n) || rdAct || sReset;
    // gate level interrupt with enable bit
    // stays high while the controller holds its request
    irq_d    = !sInt_n && outPort_q[iued_pkg::OUT_INT_EN];
    drq_d    = sDrq;
    // acknowledge stays active low toward controller
    dack_n_d = sDack_n;
    eot_d    = sTc;
    // wait driven only with chip select, value is reset
    waitOe_n_d = !ctrlHit;
    wait_d     = sReset;
    // read data mux; expansion offsets leave the bus undriven
    busDataOut_d  = 8'h00;
    busDataOe_n_d = 1'b1;
    if (rdAct && ctrlHit && (sAddr == iued_pkg::OFF_CTRL_DATA)) begin
      busDataOut_d  = ctrlDataSync;
      busDataOe_n_d = 1'b0;
    end else if (inHit) begin
      busDataOut_d  = inPortVal;
      busDataOe_n_d = 1'b0;
    end else if (rdAct && !sDack_n && !expHit) begin
      busDataOut_d  = ctrlDataSync;
      busDataOe_n_d = 1'b0;
    end
    // write data toward the controller
    ctrlDataOut_d  = sBusData;
    ctrlDataOe_n_d = !(wrAct && (ctrlHit || !sDack_n));
  end

  // register everything; outputs come only from these flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outPort_q      <= iued_pkg::OUT_PORT_RST;
      wrPrev_q       <= 1'b0;
      busDataOut_q   <= 8'h00;
      busDataOe_n_q  <= 1'b1;
      ctrlDataOut_q  <= 8'h00;
      ctrlDataOe_n_q <= 1'b1;
      dir_q          <= 1'b1;
      irq_q          <= 1'b0;
      drq_q          <= 1'b0;
      wait_q         <= 1'b0;
      waitOe_n_q     <= 1'b1;
      cs_q           <= 1'b0;
      a0_q           <= 1'b0;
      cRd_n_q        <= 1'b1;
      cWr_n_q        <= 1'b1;
      cRst_n_q       <= 1'b0;
      dack_n_q       <= 1'b1;
      eot_q          <= 1'b0;
      inEn_q         <= 1'b0;
      outStb_q       <= 1'b0;
    end else begin
      outPort_q      <= outPort_d;
      wrPrev_q       <= wrPrev_d;
      busDataOut_q   <= busDataOut_d;
      busDataOe_n_q  <= busDataOe_n_d;
      ctrlDataOut_q  <= ctrlDataOut_d;
      ctrlDataOe_n_q <= ctrlDataOe_n_d;
      dir_q          <= dir_d;
      irq_q          <= irq_d;
      drq_q          <= drq_d;
      wait_q         <= wait_d;
      waitOe_n_q     <= waitOe_n_d;
      cs_q           <= cs_d;
      a0_q           <= a0_d;
      cRd_n_q        <= cRd_n_d;
      cWr_n_q        <= cWr_n_d;
      cRst_n_q       <= cRst_n_d;
      dack_n_q       <= dack_n_d;
      eot_q          <= eot_d;
      inEn_q         <= inEn_d;
      outStb_q       <= outStb_d;
    end
  end

  // lamps lit by ones in bits 0-3
  assign test_lamp_one    = outPort_q[iued_pkg::OUT_LAMP_HI:iued_pkg::OUT_LAMP_LO];
  // suspend forced low by bit 6
  assign ctrlSuspendLow   = outPort_q[iued_pkg::OUT_SUSP];
  assign busDataOut       = busDataOut_q;
  assign busDataOe_n      = busDataOe_n_q;
  assign ctrlDataOut      = ctrlDataOut_q;
  assign ctrlDataOe_n     = ctrlDataOe_n_q;
  assign xcvrDirRead      = dir_q;
  assign busIrq           = irq_q;
  assign busDrq           = drq_q;
  assign busWaitOut       = wait_q;
  assign busWaitOe_n      = waitOe_n_q;
  assign ctrl_chip_select = cs_q;
  assign ctrlAddr0        = a0_q;
  assign ctrlRead_n       = cRd_n_q;
  assign ctrlWrite_n      = cWr_n_q;
  assign ctrlReset_n      = cRst_n_q;
  assign ctrlDmaAck_n     = dack_n_q;
  assign ctrlEot          = eot_q;
  assign inPortRdEn       = inEn_q;
  assign outPortWrStb     = outStb_q;
endmodule

/* tb/iued_isa_host.sv */
// isa host model: window and dma cycles on the board pins
module iued_isa_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] busDataOut,
  output logic            boardSel_n,
  output logic      [2:0] busAddr,
  output logic            ioRead_n,
  output logic            ioWrite_n,
  output logic            dmaAck_n,
  output logic      [7:0] busDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle strobes high; released data shows the inverse of the last byte
  initial begin
    {boardSel_n, ioRead_n, ioWrite_n, dmaAck_n} = 4'hF;
    busAddr = 3'h0;
    busDataIn = 8'hFF;
  end
  task automatic go(input logic [3:0] st, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {boardSel_n, ioRead_n, ioWrite_n, dmaAck_n} <= ~st;
    busAddr <= a;
    busDataIn <= d;
  endtask
  // read data taken at the releasing edge, then a six clock gap
  task automatic stop(output logic [7:0] q);
    @(posedge core_clk);
    q = busDataOut;
    {boardSel_n, ioRead_n, ioWrite_n, dmaAck_n} <= 4'hF;
    busDataIn <= ~busDataIn;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

/* tb/iued_glue_decoder_chk.sv */
// checker on the glue decoder ports
module iued_glue_decoder_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       busReset,
  input wire logic       boardSel_n,
  input wire logic [2:0] busAddr,
  input wire logic       ioRead_n,
  input wire logic       ioWrite_n,
  input wire logic       dmaAck_n,
  input wire logic       ctrlInt_n,
  input wire logic       ctrl_chip_select,
  input wire logic       inPortRdEn,
  input wire logic       outPortWrStb,
  input wire logic       xcvrDirRead,
  input wire logic       busWaitOe_n,
  input wire logic       busWaitOut,
  input wire logic       busIrq,
  input wire logic       ctrlReset_n,
  input wire logic       ctrlRead_n
);
  logic [53:0] hist_q;
  logic [3:0]  upCnt_q;
  logic        pRst, pSel_n, pRd_n, pWr_n, pAck_n, pInt_n, ok;
  logic [2:0]  pA;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // outputs lag pins by four or five clocks, so judge only against a steady past
  always_ff @(posedge core_clk) begin
    hist_q <= {hist_q[44:0], busReset, boardSel_n, busAddr, ioRead_n, ioWrite_n, dmaAck_n,
               ctrlInt_n};
  end
  // synchronisers refill after reset, so skip the first clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      upCnt_q <= 4'h0;
    end else if (upCnt_q != 4'hF) begin
      upCnt_q <= upCnt_q + 4'h1;
    end
  end
  assign {pRst, pSel_n, pA, pRd_n, pWr_n, pAck_n, pInt_n} = hist_q[44:36];
  assign ok = upCnt_q == 4'hF && hist_q[53:18] == {4{hist_q[44:36]}};
  a_cs_decode:
    assert property (ok |-> ctrl_chip_select == (!pSel_n && pA[2:1] == 2'h0 && !(pRd_n && pWr_n)))
    else $error("chip select wrong");
  a_inport_read:
    assert property (ok |-> inPortRdEn == (!pSel_n && pA == 3'h2 && !pRd_n))
    else $error("input read enable wrong");
  a_outport_write:
    assert property (ok |-> outPortWrStb == (!pSel_n && pA == 3'h3 && !pWr_n))
    else $error("output write strobe wrong");
  a_dir_select:
    assert property (ok |-> xcvrDirRead == ((!pSel_n && !pAck_n) || !pRd_n || pRst))
    else $error("direction wrong");
  a_wait_gate:
    assert property (ok |-> busWaitOe_n == !ctrl_chip_select)
    else $error("wait drive wrong");
  a_wait_value:
    assert property (ok && !busWaitOe_n |-> busWaitOut == pRst)
    else $error("wait value wrong");
  a_irq_gate:
    assert property (ok && pInt_n |-> !busIrq)
    else $error("irq without interrupt");
  a_ctrl_reset:
    assert property (ok |-> ctrlReset_n == !pRst && ctrlRead_n == pRd_n)
    else $error("controller reset or read wrong");
endmodule

bind iued_glue_decoder iued_glue_decoder_chk chk_u (.core_clk, .rst_n, .busReset, .boardSel_n,
  .busAddr, .ioRead_n, .ioWrite_n, .dmaAck_n, .ctrlInt_n, .ctrl_chip_select, .inPortRdEn,
  .outPortWrStb, .xcvrDirRead, .busWaitOe_n, .busWaitOut, .busIrq, .ctrlReset_n, .ctrlRead_n);

/* tb/isa_usb_eval_glue_decoder_tb.sv */
// self-checking bench for the isa usb glue decoder
module isa_usb_eval_glue_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk, rst_n, busReset, boardSel_n, ioRead_n, ioWrite_n, dmaAck_n, termCount;
  logic       busDataOe_n, xcvrDirRead, busIrq, busDrq, busWaitOut, busWaitOe_n, ctrlDataOe_n;
  logic       ctrl_chip_select, ctrlAddr0, ctrlRead_n, ctrlWrite_n, ctrlReset_n, ctrlSuspendLow;
  logic       ctrlInt_n, ctrlLink, ctrlSuspend, ctrlDmaReq, ctrlDmaAck_n, ctrlEot, usbVbus;
  logic       inPortRdEn, outPortWrStb;
  logic [2:0] busAddr;
  logic [3:0] test_button_one, test_lamp_one;
  logic [7:0] busDataIn, busDataOut, ctrlDataIn, ctrlDataOut, q;
  int         err_count, n_compared;

  iued_glue_decoder dut_u (.core_clk, .rst_n, .busReset, .boardSel_n, .busAddr, .ioRead_n,
    .ioWrite_n, .dmaAck_n, .termCount, .busDataIn, .busDataOut, .busDataOe_n, .xcvrDirRead,
    .busIrq, .busDrq, .busWaitOut, .busWaitOe_n, .ctrlDataIn, .ctrlDataOut, .ctrlDataOe_n,
    .ctrl_chip_select, .ctrlAddr0, .ctrlRead_n, .ctrlWrite_n, .ctrlReset_n, .ctrlSuspendLow,
    .ctrlInt_n, .ctrlLink, .ctrlSuspend, .ctrlDmaReq, .ctrlDmaAck_n, .ctrlEot,
    .test_button_one, .usbVbus, .test_lamp_one, .inPortRdEn, .outPortWrStb);
  iued_isa_host host_u (.core_clk, .busDataOut, .boardSel_n, .busAddr, .ioRead_n, .ioWrite_n,
    .dmaAck_n, .busDataIn);

  // 50 ns clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // strobe held six clocks so the synchronised decode has settled
  task automatic acc(input logic [2:0] a, input logic r, input logic w, input logic [7:0] d);
    host_u.go({1'b1, r, w, 1'b0}, a, d);
    repeat (6) @(posedge core_clk);
    chk("chip select", 8'(a[2:1] == 2'h0), ctrl_chip_select);
    chk("in read", 8'(r && a == 3'h2), inPortRdEn);
    chk("out write", 8'(w && a == 3'h3), outPortWrStb);
    chk("bus drive", 8'(!(r && (a == 3'h0 || a == 3'h2))), busDataOe_n);
  endtask

  task automatic t_ports();
    logic [7:0] pat [2];
    pat = '{8'hBA, 8'h45};
    chk("lamps", 8'h00, test_lamp_one);
    foreach (pat[i]) begin
      {ctrlInt_n, ctrlSuspend, usbVbus, ctrlLink, test_button_one} <= pat[i];
      acc(3'h2, 1'b1, 1'b0, 8'h00);
      host_u.stop(q);
      chk("input port", pat[i], q);
      acc(3'h3, 1'b0, 1'b1, pat[i] & 8'h7F);
      host_u.stop(q);
      chk("lamps", 8'(pat[i][3:0]), test_lamp_one);
      chk("suspend", 8'(pat[i][6]), ctrlSuspendLow);
    end
    $display("port test done");
  endtask

  task automatic t_window();
    ctrlDataIn <= 8'h3C;
    acc(3'h0, 1'b1, 1'b0, 8'h00);
    host_u.stop(q);
    chk("data read", 8'h3C, q);
    for (int a = 0; a < 2; a++) begin
      acc(3'(a), 1'b0, 1'b1, 8'h5A + 8'(a));
      chk("ctrl data", 8'h5A + 8'(a), ctrlDataOut);
      chk("ctrl addr", 8'(a), ctrlAddr0);
      chk("ctrl write", 8'h00, ctrlWrite_n);
      chk("ctrl drive", 8'h00, ctrlDataOe_n);
      chk("wait", 8'h00, {busWaitOe_n, busWaitOut});
      host_u.stop(q);
    end
    acc(3'h3, 1'b1, 1'b0, 8'h00);
    host_u.stop(q);
    for (int a = 2; a < 8; a++) begin
      if (a > 3) begin
        acc(3'(a), 1'b1, 1'b0, 8'h00);
        host_u.stop(q);
      end
      if (a != 3) begin
        acc(3'(a), 1'b0, 1'b1, 8'hFF);
        host_u.stop(q);
      end
    end
    chk("lamps", 8'h05, test_lamp_one);
    $display("window test done");
  endtask

  task automatic t_irq();
    logic [7:0] seq [4];
    seq = '{8'h80, 8'h00, 8'h80, 8'h80};
    foreach (seq[i]) begin
      ctrlInt_n <= i == 3;
      acc(3'h3, 1'b0, 1'b1, seq[i]);
      host_u.stop(q);
      repeat (20) @(posedge core_clk);
      chk("irq", 8'(seq[i][7] && i != 3), busIrq);
    end
    $display("irq test done");
  endtask

  task automatic t_dma_reset();
    ctrlDmaReq <= 1'b1;
    termCount <= 1'b1;
    host_u.go(4'h5, 3'h0, 8'h00);
    repeat (6) @(posedge core_clk);
    chk("dma", 8'h0B, {busDrq, ctrlDmaAck_n, ctrlEot, xcvrDirRead});
    host_u.stop(q);
    chk("dma read data", 8'h3C, q);
    host_u.go(4'h9, 3'h4, 8'h00);
    repeat (6) @(posedge core_clk);
    chk("dack dir", 8'h01, xcvrDirRead);
    host_u.stop(q);
    chk("idle dir", 8'h00, xcvrDirRead);
    busReset <= 1'b1;
    ctrlDmaReq <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("bus reset", 8'h02, {busDrq, ctrlReset_n, xcvrDirRead, test_lamp_one[0]});
    acc(3'h0, 1'b0, 1'b1, 8'h11);
    chk("wait", 8'h01, {busWaitOe_n, busWaitOut});
    host_u.stop(q);
    busReset <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("ctrl reset", 8'h01, ctrlReset_n);
    $display("dma and reset test done");
  endtask

  initial begin
    err_count = 0;
    n_compared = 0;
    {rst_n, busReset, termCount, ctrlInt_n, ctrlLink, ctrlSuspend, ctrlDmaReq, usbVbus} = 8'h10;
    test_button_one = 4'hF;
    ctrlDataIn = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_ports();
    t_window();
    t_irq();
    t_dma_reset();
    wrap_up();
  end

  // whole run needs just under five hundred clocks
  initial begin
    repeat (10000) @(posedge core_clk);
    err_count++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
